// File: core/smc_map.vh
// register offsets, field positions, reset values and codes of the monitor config block
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// register indices (printed offsets); byte address is four times the index
`define SMC_IDX_SYS_CTRL      6'h09
`define SMC_IDX_TRIM_LOW      6'h0A
`define SMC_IDX_TRIM_MID      6'h0B
`define SMC_IDX_TRIM_HIGH     6'h0C
// own registers for companion settings
`define SMC_IDX_AMP_CFG       6'h20
`define SMC_IDX_STATE         6'h21
// reset values
`define SMC_RST_SYS_CTRL      8'h10
`define SMC_RST_TRIM          8'h00
`define SMC_RST_AMP_CFG       8'h00
// system control fields
`define SMC_MON_HI            7
`define SMC_MON_LO            5
`define SMC_AVG_HI            4
`define SMC_AVG_LO            3
`define SMC_TMO_BIT           2
`define SMC_CRC_BIT           1
`define SMC_STAT_BIT          0
// amplifier config fields (own register)
`define SMC_GAIN_HI           2
`define SMC_GAIN_LO           0
`define SMC_PWR_HI            4
`define SMC_PWR_LO            3
// monitor codes
`define SMC_MON_OFF           3'h0
`define SMC_MON_MIDSHORT      3'h1
`define SMC_MON_TEMP          3'h2
`define SMC_MON_ASUP          3'h3
`define SMC_MON_DSUP          3'h4
`define SMC_MON_BO_0P2        3'h5
`define SMC_MON_BO_1          3'h6
`define SMC_MON_BO_10         3'h7
`define SMC_PWR_ON            2'h1
`define SMC_GAIN_ONE          3'h0
`define SMC_GAIN_MAX_TEMP     3'h2
// crc-8 polynomial x^8+x^2+x+1
`define SMC_CRC_POLY          8'h07
`define SMC_CRC_INIT          8'h00
// axi responses
`define SMC_RESP_OKAY         2'h0
`define SMC_RESP_SLVERR       2'h2
`endif

// File: core/smc_mon_decode.v
// decoder from monitor select code to analog steering controls
`include "smc_map.vh"
module smc_mon_decode (
  // selection
  input  wire [2:0] monitor_select,
  input  wire [2:0] gain_select,
  // analog steering
  output reg        mid_short_en,
  output reg        temp_sense_en,
  output reg        asup_mon_en,
  output reg        dsup_mon_en,
  output reg  [1:0] burnout_level,
  output reg        burnout_en,
  output reg        mux_open,
  output reg  [2:0] gain_eff
);
  always @*
  begin
    mid_short_en  = (monitor_select == `SMC_MON_MIDSHORT);
    temp_sense_en = (monitor_select == `SMC_MON_TEMP);
    asup_mon_en   = (monitor_select == `SMC_MON_ASUP);
    dsup_mon_en   = (monitor_select == `SMC_MON_DSUP);
    burnout_en    = monitor_select[2] & (monitor_select[1] | monitor_select[0]);
    burnout_level = monitor_select[1:0] - 2'h1;                  // 0:0.2uA 1:1uA 2:10uA
    if (!burnout_en)
    begin
      burnout_level = 2'h0;
    end
    // codes 1..4 open the input switches; zero and burn-out keep them closed
    mux_open      = mid_short_en | temp_sense_en | asup_mon_en | dsup_mon_en;
    gain_eff      = (asup_mon_en | dsup_mon_en) ? `SMC_GAIN_ONE : gain_select;
  end
endmodule // smc_mon_decode

// File: core/smc_crc8.v
// one-byte step of the crc-8 used on result framing
`include "smc_map.vh"
module smc_crc8 (
  // state in
  input  wire [7:0] crc_in,
  input  wire [7:0] data_in,
  // state out
  output reg  [7:0] crc_out
);
  integer i;
  reg [7:0] c;
  always @*
  begin
    c = crc_in ^ data_in;
    for (i = 0; i < 8; i = i + 1)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `SMC_CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule // smc_crc8

// File: core/smc_regs.v
// monitor and framing control registers with axi4-lite slave and result framer
//
// Implementation choice: the AXI4-Lite slave port.
`include "smc_map.vh"
// Behaviour
// - monitor_select sits in bits 7:5, resets to zero, and zero means normal input conversion.
// - code 001 shorts the amplifier inputs to mid-supply, cuts the input pins, keeps user gain.
// - code 010 selects the temperature sensor with user gain and needs amplifier power 01.
// - code 011 measures analog supply over four, code 100 digital supply over four, gain one.
// - codes 101, 110 and 111 turn on burn-out currents of 0.2, 1 and 10 microampere.
// - while a supply monitor is active the effective gain is one whatever gain is selected.
// - mid-short, temperature and supply monitor codes open every input multiplexer switch.
// - trim_average_count in bits 4:3 picks 1, 4, 8 or 16 samples and resets to 8.
// - bit 2 enables the serial timeout and resets clear.
// - bit 1 appends a crc byte after each result and resets clear.
// - the crc covers the 24-bit result and also the status byte when that is sent.
// - bit 0 prepends a status byte to each result and resets clear.
// - index 0Ah holds the low byte of offset_trim_value and resets to 00h.
// - offset_trim_value is 24 bits with middle byte at 0Bh and top byte at 0Ch.
module smc_regs (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // conversion result handoff from the converter core
  input  wire [23:0] result_data,
  input  wire [7:0]  result_status,
  input  wire        result_valid,
  output wire        result_ready,
  // framed byte stream toward the serial interface
  output reg  [7:0]  frame_byte,
  output reg         frame_valid,
  output reg         frame_last,
  input  wire        frame_ready,
  // analog steering
  output reg         mid_short_en,
  output reg         temp_sense_en,
  output reg         asup_mon_en,
  output reg         dsup_mon_en,
  output reg         burnout_en,
  output reg  [1:0]  burnout_level,
  output reg         mux_open,
  output reg  [2:0]  gain_eff,
  output reg  [1:0]  amplifier_power_select,
  output reg         temp_config_bad,
  // calibration and interface settings
  output reg  [4:0]  trim_average_samples,
  output wire        spi_timeout_enable,
  output wire [23:0] offset_trim_value
);
  // frame states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_STAT = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_CRC  = 4'b1000;

  reg  [7:0]  sys_ctrl_r;
  reg  [7:0]  trim_low_r;
  reg  [7:0]  trim_mid_r;
  reg  [7:0]  trim_high_r;
  reg  [7:0]  amp_cfg_r;
  reg  [7:0]  awaddr_r;
  reg         aw_held_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_held_r;
  reg  [3:0]  st_r;
  reg  [3:0]  st_nxt;
  reg  [23:0] res_r;
  reg  [1:0]  bidx_r;
  reg  [7:0]  crc_r;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  wire [7:0]  crc_step;
  wire        do_write;
  wire        wr_ok;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  wire        take_res;
  wire        byte_go;
  wire        mid_d;
  wire        temp_d;
  wire        asup_d;
  wire        dsup_d;
  wire        bo_d;
  wire [1:0]  bol_d;
  wire        mux_d;
  wire [2:0]  gain_d;

  wire [2:0] monitor_select       = sys_ctrl_r[`SMC_MON_HI:`SMC_MON_LO];
  wire [1:0] trim_average_count   = sys_ctrl_r[`SMC_AVG_HI:`SMC_AVG_LO];
  wire       crc_append_enable    = sys_ctrl_r[`SMC_CRC_BIT];
  wire       status_prefix_enable = sys_ctrl_r[`SMC_STAT_BIT];

  assign spi_timeout_enable = sys_ctrl_r[`SMC_TMO_BIT];
  assign offset_trim_value  = {trim_high_r, trim_mid_r, trim_low_r};

  // write channel: address and data captured independently, in either order
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign wr_idx        = awaddr_r[7:2];
  assign wr_ok         = (awaddr_r[1:0] == 2'h0) &&
                         ((wr_idx == `SMC_IDX_SYS_CTRL) || (wr_idx == `SMC_IDX_TRIM_LOW) ||
                          (wr_idx == `SMC_IDX_TRIM_MID) || (wr_idx == `SMC_IDX_TRIM_HIGH) ||
                          (wr_idx == `SMC_IDX_AMP_CFG));

  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SMC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // registers: only byte lane 0 carries data, upper lanes ignored
  always @(posedge clk)
  begin
    if (srst)
    begin
      sys_ctrl_r  <= `SMC_RST_SYS_CTRL;
      trim_low_r  <= `SMC_RST_TRIM;
      trim_mid_r  <= `SMC_RST_TRIM;
      trim_high_r <= `SMC_RST_TRIM;
      amp_cfg_r   <= `SMC_RST_AMP_CFG;
    end
    else if (do_write && wr_ok && wstrb_r[0])
    begin
      case (wr_idx)
        `SMC_IDX_SYS_CTRL:  sys_ctrl_r  <= wdata_r[7:0];
        `SMC_IDX_TRIM_LOW:  trim_low_r  <= wdata_r[7:0];
        `SMC_IDX_TRIM_MID:  trim_mid_r  <= wdata_r[7:0];
        `SMC_IDX_TRIM_HIGH: trim_high_r <= wdata_r[7:0];
        `SMC_IDX_AMP_CFG:   amp_cfg_r   <= wdata_r[7:0];
        default:            amp_cfg_r   <= amp_cfg_r;
      endcase
    end
  end

  // read channel: one read at a time, data from a register
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[7:2];

  always @*
  begin
    rd_hit  = (s_axi_araddr[1:0] == 2'h0);
    rd_byte = 8'h00;
    case (rd_idx)
      `SMC_IDX_SYS_CTRL:  rd_byte = sys_ctrl_r;
      `SMC_IDX_TRIM_LOW:  rd_byte = trim_low_r;
      `SMC_IDX_TRIM_MID:  rd_byte = trim_mid_r;
      `SMC_IDX_TRIM_HIGH: rd_byte = trim_high_r;
      `SMC_IDX_AMP_CFG:   rd_byte = amp_cfg_r;
      `SMC_IDX_STATE:     rd_byte = {temp_config_bad, mux_open, burnout_en, 1'b0, st_r};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SMC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, (rd_hit ? rd_byte : 8'h00)};
      s_axi_rresp  <= rd_hit ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // monitor steering; registered so the analog switches see no decode glitches
  smc_mon_decode u_decode (
    .monitor_select (monitor_select),
    .gain_select    (amp_cfg_r[`SMC_GAIN_HI:`SMC_GAIN_LO]),
    .mid_short_en   (mid_d),
    .temp_sense_en  (temp_d),
    .asup_mon_en    (asup_d),
    .dsup_mon_en    (dsup_d),
    .burnout_level  (bol_d),
    .burnout_en     (bo_d),
    .mux_open       (mux_d),
    .gain_eff       (gain_d)
  );

  always @(posedge clk)
  begin
    if (srst)
    begin
      mid_short_en           <= 1'b0;
      temp_sense_en          <= 1'b0;
      asup_mon_en            <= 1'b0;
      dsup_mon_en            <= 1'b0;
      burnout_en             <= 1'b0;
      burnout_level          <= 2'h0;
      mux_open               <= 1'b0;
      gain_eff               <= `SMC_GAIN_ONE;
      amplifier_power_select <= 2'h0;
      temp_config_bad        <= 1'b0;
      trim_average_samples   <= 5'h08;
    end
    else
    begin
      mid_short_en           <= mid_d;
      temp_sense_en          <= temp_d;
      asup_mon_en            <= asup_d;
      dsup_mon_en            <= dsup_d;
      burnout_en             <= bo_d;
      burnout_level          <= bol_d;
      mux_open               <= mux_d;
      gain_eff               <= gain_d;
      amplifier_power_select <= amp_cfg_r[`SMC_PWR_HI:`SMC_PWR_LO];
      // flag only; the device cannot stop software from a bad setup
      temp_config_bad        <= temp_d &&
                                ((amp_cfg_r[`SMC_PWR_HI:`SMC_PWR_LO] != `SMC_PWR_ON) ||
                                 (amp_cfg_r[`SMC_GAIN_HI:`SMC_GAIN_LO] > `SMC_GAIN_MAX_TEMP));
      case (trim_average_count)
        2'h0:    trim_average_samples <= 5'h01;
        2'h1:    trim_average_samples <= 5'h04;
        2'h2:    trim_average_samples <= 5'h08;
        default: trim_average_samples <= 5'h10;
      endcase
    end
  end

  // result framer: [status] msb..lsb [crc]
  assign take_res     = (st_r == ST_IDLE) && result_valid;
  assign result_ready = (st_r == ST_IDLE);
  assign byte_go      = frame_valid && frame_ready;

  smc_crc8 u_crc (
    .crc_in  (crc_r),
    .data_in (frame_byte),
    .crc_out (crc_step)
  );

  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (take_res) st_nxt = status_prefix_enable ? ST_STAT : ST_DATA;
      ST_STAT: if (byte_go) st_nxt = ST_DATA;
      ST_DATA: if (byte_go && bidx_r == 2'h2) st_nxt = crc_append_enable ? ST_CRC : ST_IDLE;
      ST_CRC:  if (byte_go) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      st_r        <= ST_IDLE;
      res_r       <= 24'h00_0000;
      bidx_r      <= 2'h0;
      crc_r       <= `SMC_CRC_INIT;
      frame_byte  <= 8'h00;
      frame_valid <= 1'b0;
      frame_last  <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (take_res)
      begin
        res_r       <= result_data;
        bidx_r      <= 2'h0;
        crc_r       <= `SMC_CRC_INIT;
        frame_valid <= 1'b1;
        frame_byte  <= status_prefix_enable ? result_status : result_data[23:16];
        frame_last  <= ~status_prefix_enable & 1'b0;
      end
      else if (byte_go)
      begin
        // crc folds in every byte sent before it, status included when sent
        crc_r <= crc_step;
        case (st_r)
          ST_STAT:
          begin
            frame_byte <= res_r[23:16];
          end
          ST_DATA:
          begin
            if (bidx_r == 2'h2)
            begin
              frame_valid <= crc_append_enable;
              frame_byte  <= crc_append_enable ? crc_step : 8'h00;
              frame_last  <= crc_append_enable;
            end
            else
            begin
              bidx_r     <= bidx_r + 2'h1;
              frame_byte <= (bidx_r == 2'h0) ? res_r[15:8] : res_r[7:0];
              frame_last <= (bidx_r == 2'h1) && !crc_append_enable;
            end
          end
          default:
          begin
            frame_valid <= 1'b0;
            frame_last  <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // smc_regs

// File: bench/smc_regs_properties.sv
// concurrent checks on the monitor config register block ports
module smc_regs_props (
  // clock and reset
  input logic       clk,
  input logic       srst,
  // register bus
  input logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic       s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // framing
  input logic       result_ready, frame_valid, frame_ready,
  input logic [7:0] frame_byte,
  // steering and settings
  input logic       mid_short_en, temp_sense_en, asup_mon_en, dsup_mon_en,
  input logic       burnout_en, mux_open, spi_timeout_enable,
  input logic [2:0] gain_eff,
  input logic [4:0] trim_average_samples,
  input logic [23:0] offset_trim_value
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_frm_stall;
    frame_valid && !frame_ready;
  endsequence
  property p_mux;
    mux_open == (mid_short_en || temp_sense_en || asup_mon_en || dsup_mon_en);
  endproperty
  a_mux: assert property (p_mux) else $error("mux state wrong");
  property p_gain;
    (asup_mon_en || dsup_mon_en) |-> gain_eff == 3'h0;
  endproperty
  a_gain: assert property (p_gain) else $error("gain not one");
  property p_bo;
    burnout_en |-> !mux_open && !mid_short_en && !temp_sense_en;
  endproperty
  a_bo: assert property (p_bo) else $error("burn-out mix");
  property p_one;
    $onehot0({mid_short_en, temp_sense_en, asup_mon_en, dsup_mon_en, burnout_en});
  endproperty
  a_one: assert property (p_one) else $error("two monitors on");
  property p_avg;
    trim_average_samples inside {5'h01, 5'h04, 5'h08, 5'h10};
  endproperty
  a_avg: assert property (p_avg) else $error("bad sample count");
  // checked through reset itself, so no disable here
  property p_rst;
    disable iff (1'b0) srst |=> trim_average_samples == 5'h08 && !mux_open
      && !spi_timeout_enable && offset_trim_value == 24'h000000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_wr;
    s_wr_both |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("no write answer");
  property p_rd;
    s_rd_take |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  property p_ref;
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
  endproperty
  a_ref: assert property (p_ref) else $error("request taken while busy");
  property p_fhold;
    s_frm_stall |=> frame_valid && $stable(frame_byte) && !result_ready;
  endproperty
  a_fhold: assert property (p_fhold) else $error("frame byte dropped");
endmodule // smc_regs_props
bind smc_regs smc_regs_props smc_regs_props_i (.clk(clk), .srst(srst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .result_ready(result_ready),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_byte(frame_byte),
  .mid_short_en(mid_short_en), .temp_sense_en(temp_sense_en), .asup_mon_en(asup_mon_en),
  .dsup_mon_en(dsup_mon_en), .burnout_en(burnout_en), .mux_open(mux_open),
  .spi_timeout_enable(spi_timeout_enable), .gain_eff(gain_eff),
  .trim_average_samples(trim_average_samples), .offset_trim_value(offset_trim_value));

// File: bench/testbench.sv
// self-checking bench for the monitor config register block
`include "smc_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] adr_sys = 8'(`SMC_IDX_SYS_CTRL * 4);
  localparam logic [7:0] adr_lo = 8'(`SMC_IDX_TRIM_LOW * 4);
  localparam logic [7:0] adr_mid = 8'(`SMC_IDX_TRIM_MID * 4);
  localparam logic [7:0] adr_hi = 8'(`SMC_IDX_TRIM_HIGH * 4);
  localparam logic [7:0] adr_amp = 8'(`SMC_IDX_AMP_CFG * 4);
  logic        clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, result_valid, result_ready, frame_valid, frame_last, frame_ready;
  logic        mid_short_en, temp_sense_en, asup_mon_en, dsup_mon_en, burnout_en, mux_open;
  logic        temp_config_bad, spi_timeout_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, result_status, frame_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, burnout_level, amplifier_power_select;
  logic [23:0] result_data, offset_trim_value;
  logic [2:0]  gain_eff;
  logic [4:0]  trim_average_samples;
  logic [11:0] e;
  logic [7:0]  q[$];
  int          errors, tests_run, cycles;
  smc_regs smc_regs_i (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .result_data(result_data), .result_status(result_status),
    .result_valid(result_valid), .result_ready(result_ready), .frame_byte(frame_byte),
    .frame_valid(frame_valid), .frame_last(frame_last), .frame_ready(frame_ready),
    .mid_short_en(mid_short_en), .temp_sense_en(temp_sense_en), .asup_mon_en(asup_mon_en),
    .dsup_mon_en(dsup_mon_en), .burnout_en(burnout_en), .burnout_level(burnout_level),
    .mux_open(mux_open), .gain_eff(gain_eff), .amplifier_power_select(amplifier_power_select),
    .temp_config_bad(temp_config_bad), .trim_average_samples(trim_average_samples),
    .spi_timeout_enable(spi_timeout_enable), .offset_trim_value(offset_trim_value));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // readies are looked at on the falling edge, so the next rising edge is the handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = `SMC_RESP_OKAY);
    logic ta, tw, bv;
    logic [1:0] r;
    bv = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    ta = 0;
    tw = 0;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ta = ta || s_axi_awready === 1'b1;
      tw = tw || s_axi_wready === 1'b1;
      @(posedge clk);
      if (ta)
        s_axi_awvalid <= 0;
      if (tw)
        s_axi_wvalid <= 0;
    end
    while (!bv)
    begin
      @(negedge clk);
      bv = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge clk);
    end
    s_axi_bready <= 0;
    check(32'(r), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x,
                    input logic [1:0] er = `SMC_RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 0;
    check(d, {24'h000000, x});
    check(32'(r), 32'(er));
  endtask
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    repeat (8) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction
  // frame_ready toggles every cycle so each byte but the first of the first frame also sees a stall
  task automatic frame(input logic [23:0] d, input logic [7:0] st, input logic [1:0] cfg);
    logic [7:0] c;
    int i;
    q = {};
    c = 8'h00;
    if (cfg[0])
      q.push_back(st);
    q.push_back(d[23:16]);
    q.push_back(d[15:8]);
    q.push_back(d[7:0]);
    foreach (q[k]) c = crc_step(c, q[k]);
    if (cfg[1])
      q.push_back(c);
    @(posedge clk);
    result_data <= d;
    result_status <= st;
    result_valid <= 1;
    do @(negedge clk); while (result_ready !== 1'b1);
    @(posedge clk);
    result_valid <= 0;
    i = 0;
    while (i < q.size())
    begin
      @(negedge clk);
      if (frame_valid === 1'b1 && frame_ready)
      begin
        check(32'(frame_byte), 32'(q[i]));
        check(32'(frame_last), 32'(i == q.size() - 1));
        i++;
      end
      @(posedge clk);
      frame_ready <= ~frame_ready;
    end
  endtask
  task automatic reset_and_check;
    @(posedge clk);
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
    rd(adr_sys, `SMC_RST_SYS_CTRL);
    rd(adr_lo, 8'h00);
    rd(adr_mid, 8'h00);
    rd(adr_hi, 8'h00);
    rd(8'h84, 8'h01);
    check(32'({spi_timeout_enable, mux_open, trim_average_samples}), 32'h08);
  endtask
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      summarize();
    end
  end
  initial
  begin
    srst = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {result_data, result_status, result_valid, frame_ready} = 34'h1;
    reset_and_check();
    wr(adr_lo, 8'hA5);
    wr(adr_mid, 8'h3C);
    wr(adr_hi, 8'h5A);
    check(32'(offset_trim_value), 32'h5A3CA5);
    wr(adr_lo, 8'h11, 4'h0);
    rd(adr_lo, 8'hA5);
    wr(8'h40, 8'h11, 4'hF, `SMC_RESP_SLVERR);
    wr(8'h29, 8'h11, 4'hF, `SMC_RESP_SLVERR);
    rd(8'h40, 8'h00, `SMC_RESP_SLVERR);
    // user gain code 5 with amplifier power 01
    wr(adr_amp, 8'h0D);
    rd(adr_amp, 8'h0D);
    for (int m = 0; m < 8; m++)
    begin
      wr(adr_sys, {m[2:0], 5'h10});
      @(negedge clk);
      e = {m == 1, m == 2, m == 3, m == 4, m > 4, 2'(m > 4 ? m - 5 : 0), m > 0 && m < 5,
           (m == 3 || m == 4) ? 3'h0 : 3'h5, m == 2};
      check(32'({mid_short_en, temp_sense_en, asup_mon_en, dsup_mon_en, burnout_en,
                 burnout_level, mux_open, gain_eff, temp_config_bad}), 32'(e));
      rd(adr_sys, {m[2:0], 5'h10});
    end
    wr(adr_sys, 8'h50);
    wr(adr_amp, 8'h0A);
    @(negedge clk);
    check(32'({amplifier_power_select, temp_config_bad, gain_eff}), 32'h12);
    wr(adr_amp, 8'h02);
    @(negedge clk);
    check(32'({amplifier_power_select, temp_config_bad, gain_eff}), 32'h0A);
    for (int k = 0; k < 4; k++)
    begin
      wr(adr_sys, {3'h0, k[1:0], 3'h0});
      @(negedge clk);
      check(32'(trim_average_samples), k == 0 ? 32'h1 : 32'h2 << k);
    end
    wr(adr_sys, 8'h04);
    check(32'(spi_timeout_enable), 32'h1);
    for (int f = 0; f < 4; f++)
    begin
      wr(adr_sys, {6'h04, f[1:0]});
      frame(24'hC3A51F + 24'(f), 8'h80 | 8'(f), f[1:0]);
    end
    wr(adr_hi, 8'h77);
    reset_and_check();
    summarize();
  end
endmodule // testbench
